// >>> logic/lcd_geom_pkg.sv
// constants and carrier types for the lcd host port with busy and geometry
// assumes one 100 MHz clock and a host port sampled synchronously
package lcd_geom_pkg;
   localparam int          CLK_MHZ       = 100;
   // instruction execution time; arbitrary value, not given for the block
   localparam int          EXEC_TIME_NS  = 1000;
   localparam int          EXEC_CYCLES   =
      (EXEC_TIME_NS * CLK_MHZ + 999) / 1000;
   // instruction codes that load a geometry setting, then IR_RESET, the undecoded code held after reset
   localparam logic [7:0]  IR_PITCH      = 8'h01;
   localparam logic [7:0]  IR_CHARS      = 8'h02;
   localparam logic [7:0]  IR_DUTY       = 8'h03;
   localparam logic [7:0]  IR_CURSOR     = 8'h04;
   localparam logic [7:0]  IR_RESET      = 8'h00;
   // field positions inside the pitch byte: vert-1 low, horiz-1 high, then the busy bit of the status byte
   localparam int          VP_LSB        = 0;
   localparam int          HP_LSB        = 4;
   localparam int          STATUS_BIT    = 7;
   // settings after reset, then the horizontal pitch clamp limits
   localparam logic [3:0]  HP_RESET      = 4'h8;
   localparam logic [4:0]  VP_RESET      = 5'h08;
   localparam logic [8:0]  HN_RESET      = 9'h014;
   localparam logic [8:0]  NX_RESET      = 9'h040;
   localparam logic [4:0]  CP_RESET      = 5'h08;
   localparam logic [3:0]  HP_MIN        = 4'h6;
   localparam logic [3:0]  HP_MAX        = 4'h8;

   typedef struct packed {
      logic       rd;     // 1 = read access
      logic       rs;     // register_select
      logic [7:0] data;   // host write data
   } host_req_t;

   typedef struct packed {
      logic [3:0]  char_pitch_horiz;
      logic [4:0]  char_pitch_vert;
      logic [8:0]  chars_per_row;
      logic [8:0]  duty_lines;
      logic [4:0]  cursor_row;
      logic [11:0] h_dots;
      logic [8:0]  text_rows;
   } geometry_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } exec_state_t;
endpackage

// >>> logic/lcd_host_port.sv
// lcd controller parallel host port: busy status and screen geometry
// assumes host strobes are one clock wide and synchronous to clk
`timescale 1ns/10ps
module lcd_host_port
#(
   parameter int EXEC_CYC = lcd_geom_pkg::EXEC_CYCLES
)
(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   access_stb,
   input  wire lcd_geom_pkg::host_req_t host_req,
   output logic [7:0]                  data_bus_out,
   output logic                        data_bus_oe_n,
   output logic                        busy,
   output lcd_geom_pkg::geometry_t     geometry
);
   import lcd_geom_pkg::*;

   if (EXEC_CYC < 1 || EXEC_CYC > 65535)
   begin : g_bad_exec
      $error("EXEC_CYC out of range");
   end

   exec_state_t state_q;
   exec_state_t state_d;
   logic [15:0] exec_cnt_q;
   logic [7:0]  instr_q;
   logic [7:0]  data_bus_out_q;
   logic        data_bus_oe_n_q;
   logic        busy_q;
   geometry_t   geo_q;
   geometry_t   geo_d;

   wire         wr_instr   = access_stb && !host_req.rd && host_req.rs;
   wire         wr_data    = access_stb && !host_req.rd && !host_req.rs;
   wire         rd_status  = access_stb && host_req.rd && host_req.rs;
   wire         rd_data    = access_stb && host_req.rd && !host_req.rs;
   wire         accept     = wr_data && (state_q == ST_IDLE);
   wire         exec_done  = (state_q == ST_EXEC) && (exec_cnt_q == 16'h0001);
   wire [7:0]   status_byte = {busy_q, 7'h00};

   function automatic logic [3:0] clamp_hp(input logic [2:0] raw);
      logic [3:0] v;
      v = {1'b0, raw} + 4'h1;
      if (v < HP_MIN)
         clamp_hp = HP_MIN;
      else if (v > HP_MAX)
         clamp_hp = HP_MAX;
      else
         clamp_hp = v;
   endfunction

   // every request rounds up to the next even count above it, so even requests gain two
   function automatic logic [8:0] even_hn(input logic [7:0] raw);
      even_hn = {1'b0, raw[7:1], 1'b1} + 9'h001;
   endfunction

   function automatic logic [4:0] clamp_cp(input logic [3:0] raw,
                                           input logic [4:0] vp);
      logic [4:0] v;
      v = {1'b0, raw} + 5'h01;
      clamp_cp = (v > vp) ? vp : v;
   endfunction

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: if (accept) state_d = ST_EXEC;
         ST_EXEC: if (exec_done) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_comb
   begin
      geo_d = geo_q;
      if (accept)
      begin
         unique case (instr_q)
            IR_PITCH:
            begin
               geo_d.char_pitch_horiz =
                  clamp_hp(host_req.data[HP_LSB +: 3]);
               geo_d.char_pitch_vert  =
                  {1'b0, host_req.data[VP_LSB +: 4]} + 5'h01;
               geo_d.cursor_row = clamp_cp(4'(geo_q.cursor_row - 5'h01),
                  {1'b0, host_req.data[VP_LSB +: 4]} + 5'h01);
            end
            IR_CHARS:  geo_d.chars_per_row = even_hn(host_req.data);
            IR_DUTY:   geo_d.duty_lines =
                          {1'b0, host_req.data} + 9'h001;
            IR_CURSOR: geo_d.cursor_row =
                          clamp_cp(host_req.data[3:0],
                                   geo_q.char_pitch_vert);
            default: ;
         endcase
      end
      geo_d.h_dots    =
         12'(geo_d.char_pitch_horiz * geo_d.chars_per_row);
      geo_d.text_rows =
         9'(geo_d.duty_lines / geo_d.char_pitch_vert);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q    <= ST_IDLE;
         exec_cnt_q <= 16'h0000;
         busy_q     <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         // busy follows execution only; instruction writes never touch it
         exec_cnt_q <= accept ? 16'(EXEC_CYC) :
                       (exec_cnt_q != 16'h0000) ? exec_cnt_q - 16'h0001 :
                       16'h0000;
         busy_q     <= (state_d == ST_EXEC);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         instr_q <= IR_RESET;
      else if (wr_instr)
         instr_q <= host_req.data;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         data_bus_out_q  <= 8'h00;
         data_bus_oe_n_q <= 1'b1;
      end
      else
      begin
         data_bus_oe_n_q <= !(rd_status || rd_data);
         if (rd_status)
            data_bus_out_q <= status_byte;
         else if (rd_data)
            data_bus_out_q <= instr_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         geo_q.char_pitch_horiz <= HP_RESET;
         geo_q.char_pitch_vert  <= VP_RESET;
         geo_q.chars_per_row    <= HN_RESET;
         geo_q.duty_lines       <= NX_RESET;
         geo_q.cursor_row       <= CP_RESET;
         geo_q.h_dots           <= 12'(HP_RESET * HN_RESET);
         geo_q.text_rows        <= 9'(NX_RESET / VP_RESET);
      end
      else
         geo_q <= geo_d;
   end

   assign data_bus_out  = data_bus_out_q;
   assign data_bus_oe_n = data_bus_oe_n_q;
   assign busy          = busy_q;
   assign geometry      = geo_q;

   // ---- checks ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_accept;
      accept;
   endsequence
   sequence s_busy_run;
      busy_q [*1];
   endsequence

   a_status_read_msb: assert property (
      rd_status |=> !data_bus_oe_n_q
                    && data_bus_out_q[STATUS_BIT] == $past(busy_q)
                    && data_bus_out_q[6:0] == 7'h00)
      else $error("status read did not show busy on msb");
   a_busy_starts: assert property (
      s_accept |=> s_busy_run)
      else $error("busy not set after accepted instruction");
   // busy length is held by the counter: loaded full, ends at one
   a_busy_length: assert property (
      $rose(busy_q) |-> exec_cnt_q == 16'(EXEC_CYC))
      else $error("busy length wrong");
   a_busy_ends: assert property (
      busy_q |=> busy_q == ($past(exec_cnt_q) != 16'h0001))
      else $error("busy did not end with the count");
   a_busy_refuse: assert property (
      busy_q && wr_data |=> $stable(geo_q.duty_lines)
                            && $stable(geo_q.chars_per_row))
      else $error("instruction taken while busy");
   a_instr_no_busy: assert property (
      wr_instr && !busy_q |=> !busy_q)
      else $error("instruction register write changed busy");
   a_pitch_range: assert property (
      geo_q.char_pitch_horiz inside {[4'h6:4'h8]}
      && geo_q.char_pitch_vert inside {[5'h01:5'h10]})
      else $error("pitch out of range");
   a_chars_even: assert property (
      !geo_q.chars_per_row[0] && geo_q.chars_per_row >= 9'h002)
      else $error("characters per row not even");
   a_cursor_limit: assert property (
      geo_q.cursor_row >= 5'h01 && geo_q.cursor_row <= geo_q.char_pitch_vert)
      else $error("cursor row outside pitch");
   a_duty_load: assert property (
      accept && instr_q == IR_DUTY |=>
      geo_q.duty_lines == {1'b0, $past(host_req.data)} + 9'h001)
      else $error("duty lines not loaded");
   a_dots_product: assert property (
      geo_q.h_dots == 12'(geo_q.char_pitch_horiz * geo_q.chars_per_row)
      && geo_q.text_rows == 9'(geo_q.duty_lines / geo_q.char_pitch_vert))
      else $error("geometry products wrong");
endmodule

// >>> test/lcd_host_model.sv
// host microcontroller model for the lcd host port
// assumes the port takes access_stb on the rising edge of clk
`timescale 1ns/10ps
module lcd_host_model
(
   input  wire logic                clk,
   output lcd_geom_pkg::host_req_t  host_req,
   output logic                     access_stb,
   input  wire logic [7:0]          data_bus_out,
   input  wire logic                data_bus_oe_n
);
   import lcd_geom_pkg::*;
   int poll_fail = 0;
   initial
   begin
      access_stb = 1'b0;
      host_req   = '0;
   end
   // data lines toggle once released, so stale values never pass
   task automatic xfer(input logic rd, input logic rs, input logic [7:0] d,
                       output logic [7:0] q);
   begin
      @(posedge clk);
      access_stb <= 1'b1;
      host_req   <= '{rd: rd, rs: rs, data: d};
      @(posedge clk);
      access_stb    <= 1'b0;
      host_req.data <= ~d;
      #1;
      q = (data_bus_oe_n === 1'b0) ? data_bus_out : 8'hXX;
   end
   endtask
   task automatic status(output logic b);
      logic [7:0] q;
   begin
      xfer(1'b1, 1'b1, 8'h00, q);
      b = q[STATUS_BIT];
   end
   endtask
   task automatic idle();
      logic b;
      int   n;
   begin
      n = 0;
      status(b);
      while (b !== 1'b0 && n < 40)
      begin
         status(b);
         n++;
      end
      // a poll that never sees idle is counted, not silently dropped
      if (b !== 1'b0)
         poll_fail++;
   end
   endtask
   task automatic exec(input logic [7:0] ir, input logic [7:0] arg);
      logic [7:0] q;
   begin
      idle();
      xfer(1'b0, 1'b1, ir, q);
      xfer(1'b0, 1'b0, arg, q);
   end
   endtask
endmodule

// >>> test/tb_lcd_host_port.sv
// self-checking bench for the lcd host port
// assumes lcd_host_model stands in for the host controller
`timescale 1ns/10ps
module tb_lcd_host_port;
   import lcd_geom_pkg::*;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       access_stb;
   host_req_t  host_req;
   logic [7:0] data_bus_out;
   logic       data_bus_oe_n;
   logic       busy;
   geometry_t  geometry;
   int         err_total = 0;
   int         cmp_count = 0;
   logic       b;
   logic [7:0] q;
   localparam int EXEC_N = 10;
   always #5 clk = ~clk;
   // ten-cycle execution, shorter than the 100-cycle default, still leaves room for accesses while busy
   lcd_host_port #(.EXEC_CYC(EXEC_N)) lcd_host_port_i
   (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .access_stb    (access_stb),
      .host_req      (host_req),
      .data_bus_out  (data_bus_out),
      .data_bus_oe_n (data_bus_oe_n),
      .busy          (busy),
      .geometry      (geometry)
   );
   lcd_host_model lcd_host_model_i
   (
      .clk           (clk),
      .host_req      (host_req),
      .access_stb    (access_stb),
      .data_bus_out  (data_bus_out),
      .data_bus_oe_n (data_bus_oe_n)
   );
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
   begin
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task automatic test_done();
   begin
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   task automatic t_reset();
   begin
      chk(geometry.char_pitch_horiz, 12'h008);
      chk(geometry.chars_per_row, 12'h014);
      chk(geometry.h_dots, 12'h0A0);
      chk(geometry.text_rows, 12'h008);
      lcd_host_model_i.status(b);
      chk(b, 12'h000);
   end
   endtask
   task automatic t_busy();
   begin
      lcd_host_model_i.exec(IR_DUTY, 8'hC7);
      chk(busy, 12'h001);
      lcd_host_model_i.status(b);
      chk(b, 12'h001);
      lcd_host_model_i.xfer(1'b0, 1'b1, IR_DUTY, q);
      lcd_host_model_i.status(b);
      chk(b, 12'h001);
      lcd_host_model_i.xfer(1'b0, 1'b0, 8'h09, q);
      lcd_host_model_i.idle();
      chk(geometry.duty_lines, 12'h0C8);
      chk(geometry.text_rows, 12'h019);
      lcd_host_model_i.status(b);
      chk(b, 12'h000);
   end
   endtask
   task automatic t_pitch();
      int h;
      int e;
   begin
      for (h = 4; h <= 8; h++)
      begin
         e = (h < 6) ? 6 : h;
         lcd_host_model_i.exec(IR_PITCH, {1'b0, 3'(h - 1), 4'hF});
         lcd_host_model_i.idle();
         chk(geometry.char_pitch_horiz, 12'(e));
         chk(geometry.char_pitch_vert, 12'h010);
         chk(geometry.h_dots, 12'(e * 20));
         chk(geometry.text_rows, 12'h00C);
      end
   end
   endtask
   task automatic t_size();
   begin
      lcd_host_model_i.exec(IR_CHARS, 8'hFF);
      lcd_host_model_i.exec(IR_DUTY, 8'hFF);
      lcd_host_model_i.idle();
      chk(geometry.chars_per_row, 12'h100);
      chk(geometry.h_dots, 12'h800);
      chk(geometry.duty_lines, 12'h100);
      lcd_host_model_i.exec(IR_CHARS, 8'h04);
      lcd_host_model_i.idle();
      chk(geometry.chars_per_row, 12'h006);
      lcd_host_model_i.exec(IR_PITCH, 8'h73);
      lcd_host_model_i.exec(IR_CURSOR, 8'h0F);
      lcd_host_model_i.idle();
      chk(geometry.cursor_row, 12'h004);
      chk(geometry.text_rows, 12'h040);
      lcd_host_model_i.exec(IR_CURSOR, 8'h01);
      lcd_host_model_i.idle();
      chk(geometry.cursor_row, 12'h002);
   end
   endtask
   task automatic t_busy_len();
      int n;
   begin
      // undecoded code still runs the full time and changes nothing
      lcd_host_model_i.exec(8'h05, 8'h3C);
      n = 0;
      while (busy === 1'b1 && n < 200)
      begin
         n++;
         @(posedge clk);
         #1;
      end
      chk(12'(n), 12'(EXEC_N));
      chk(geometry.chars_per_row, 12'h006);
      chk(geometry.h_dots, 12'h030);
   end
   endtask
   task automatic t_readback();
   begin
      lcd_host_model_i.xfer(1'b0, 1'b1, IR_CHARS, q);
      chk(busy, 12'h000);
      lcd_host_model_i.xfer(1'b1, 1'b0, 8'h00, q);
      chk(q, 12'(IR_CHARS));
      lcd_host_model_i.xfer(1'b0, 1'b0, 8'h09, q);
      lcd_host_model_i.idle();
      chk(geometry.chars_per_row, 12'h00A);
      chk(geometry.h_dots, 12'h050);
   end
   endtask
   initial
   begin
      #200000;
      err_total++;
      test_done();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_busy();
      t_pitch();
      t_size();
      t_busy_len();
      t_readback();
      chk(12'(lcd_host_model_i.poll_fail), 12'h000);
      test_done();
   end
endmodule
